// ==== bench/dsm_mem_model.sv ====
// Purpose: data ram, y ram and program memory seen by the router
// Assumes: each memory answers in the cycle after its strobe
// Notes:   idle buses churn so stale data never passes for an answer
`timescale 1ns/1ps
module dsm_mem_model (
  input  wire logic        clk_in,
  input  wire logic        ram_re_in,
  input  wire logic [15:0] ram_addr_in,
  input  wire logic        yram_re_in,
  input  wire logic [15:0] yram_addr_in,
  input  wire logic        pm_re_in,
  input  wire logic [23:0] pm_addr_in,
  output logic      [15:0] ram_rdata_out,
  output logic      [15:0] yram_rdata_out,
  output logic      [23:0] pm_rdata_out
);
  // known start values; an unknown would hide a capture in the wrong cycle
  initial
  begin
    ram_rdata_out  = 16'h5a5a;
    yram_rdata_out = 16'ha5a5;
    pm_rdata_out   = 24'h3c3c3c;
  end

  // both rams hold one content; the upper program byte is junk on purpose
  always @(posedge clk_in)
  begin
    ram_rdata_out  <= ram_re_in ? {ram_addr_in[7:0] ^ 8'h96, ram_addr_in[7:0]} : ~ram_rdata_out;
    yram_rdata_out <= yram_re_in ? {yram_addr_in[7:0] ^ 8'h96, yram_addr_in[7:0]}
                                 : ~yram_rdata_out;
    pm_rdata_out   <= pm_re_in ? {8'hff, pm_addr_in[15:0] ^ {2{pm_addr_in[23:16]}}}
                               : ~pm_rdata_out;
  end
endmodule

// ==== bench/tb_top.sv ====
// Purpose: self-checking bench for the data space router
// Assumes: memories behind the router are the behavioural model
// Notes:   random traffic from a fixed seed, forced corners first
`timescale 1ns/1ps
module tb_top;
  import dsm_pkg::*;
  logic        clk_in = 1'b0, rstn_in = 1'b1;
  logic        win_en = 1'b0, tbusy = 1'b0, x_req = 1'b0, x_we = 1'b0, y_req = 1'b0;
  logic [4:0]  rep = 5'h00;
  logic [7:0]  page = 8'h00;
  logic [15:0] x_ea = 16'h0, x_ms = 16'h0, x_me = 16'h0, x_wd = 16'h0;
  logic [15:0] y_ea = 16'h0, y_ms = 16'h0, y_me = 16'h0;
  dsm_kind_t   kind = KIND_OTHER;
  dsm_ptr_t    x_ptr = PTR_OTHER, y_ptr = PTR_OTHER;
  dsm_amode_t  x_am = AMODE_LINEAR, y_am = AMODE_LINEAR;
  logic        ready, done, drop, ram_re, ram_we, yram_re, pm_re;
  logic [15:0] x_rd, y_rd, ram_addr, ram_wd, ram_rd, yram_addr, yram_rd;
  logic [23:0] pm_addr, pm_rd;
  int          miscompares = 0, samples_checked = 0, seed = 76;
  int          n_rr, n_rw, n_yr, n_pm, n_dr;
  logic [23:0] a_rr, a_rw, d_rw, a_yr, a_pm;

  dsm_data_router #(.RAM_BYTES(256), .BR_BITS(7)) i_dut (
    .clk_in(clk_in), .rstn_in(rstn_in), .ce_in(1'b1),
    .program_window_enable_in(win_en), .program_window_page_in(page),
    .table_busy_in(tbusy), .kind_in(kind), .rep_active_in(rep[4]),
    .rep_first_in(rep[3]), .rep_last_in(rep[2]), .rep_irq_exit_in(rep[1]),
    .rep_irq_reentry_in(rep[0]), .x_req_in(x_req), .x_we_in(x_we), .x_ea_in(x_ea),
    .x_ptr_in(x_ptr), .x_amode_in(x_am), .x_mod_start_in(x_ms), .x_mod_end_in(x_me),
    .x_wdata_in(x_wd), .y_req_in(y_req), .y_ea_in(y_ea), .y_ptr_in(y_ptr),
    .y_amode_in(y_am), .y_mod_start_in(y_ms), .y_mod_end_in(y_me),
    .ready_out(ready), .done_out(done), .x_rdata_out(x_rd), .y_rdata_out(y_rd),
    .win_write_drop_out(drop), .ram_re_out(ram_re), .ram_we_out(ram_we),
    .ram_addr_out(ram_addr), .ram_wdata_out(ram_wd), .ram_rdata_in(ram_rd),
    .yram_re_out(yram_re), .yram_addr_out(yram_addr), .yram_rdata_in(yram_rd),
    .pm_re_out(pm_re), .pm_addr_out(pm_addr), .pm_rdata_in(pm_rd));

  dsm_mem_model i_mem (
    .clk_in(clk_in), .ram_re_in(ram_re), .ram_addr_in(ram_addr), .yram_re_in(yram_re),
    .yram_addr_in(yram_addr), .pm_re_in(pm_re), .pm_addr_in(pm_addr),
    .ram_rdata_out(ram_rd), .yram_rdata_out(yram_rd), .pm_rdata_out(pm_rd));

  // 20 mhz core clock
  initial
  begin
    forever #25 clk_in = ~clk_in;
  end

  // tally strobes so every access can be traced to its path
  always @(posedge clk_in)
  begin
    if (ram_re === 1'b1) n_rr++;
    if (ram_re === 1'b1) a_rr = ram_addr;
    if (ram_we === 1'b1) n_rw++;
    if (ram_we === 1'b1) a_rw = ram_addr;
    if (ram_we === 1'b1) d_rw = ram_wd;
    if (yram_re === 1'b1) n_yr++;
    if (yram_re === 1'b1) a_yr = yram_addr;
    if (pm_re === 1'b1) n_pm++;
    if (pm_re === 1'b1) a_pm = pm_addr;
    if (drop === 1'b1) n_dr++;
  end

  function automatic logic [15:0] mem(input logic [15:0] a);
    return {a[7:0] ^ 8'h96, a[7:0]};
  endfunction

  // low word of the model's program word at a 24-bit address
  function automatic logic [15:0] pmw(input logic [23:0] a);
    return a[15:0] ^ {2{a[23:16]}};
  endfunction

  // modifier as the core defines it; reversal only where allowed
  function automatic logic [15:0] adj(input logic [15:0] ea, input dsm_amode_t m,
                                      input logic [15:0] s, input logic [15:0] e,
                                      input logic br);
    logic [15:0] r;
    r = ea;
    if (m == AMODE_MODULO && ea > e) r = s + (ea - e - 16'h0002);
    if (m == AMODE_MODULO && ea < s) r = e + 16'h0002 - (s - ea);
    if (m == AMODE_BITREV && br)
      for (int i = 1; i <= 7; i++) r[i] = ea[8 - i];
    return r;
  endfunction

  // even address in one of the four interesting regions
  function automatic logic [15:0] rnd_ea(input logic [31:0] r, input logic [31:0] q);
    case (q[1:0])
      2'h0: return 16'(r) & 16'h007e;
      2'h1: return 16'h0080 | (16'(r) & 16'h007e);
      2'h2: return 16'h0100 | (16'(r) & 16'h7efe);
      default: return 16'h8000 | (16'(r) & 16'h7ffe);
    endcase
  endfunction

  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up();
    if (miscompares == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // one access: expectations from the stimulus, then take and wait
  task automatic go();
    logic [15:0] xa, ya, xe, ye;
    logic        acc, win, xok, yok, yq, pr;
    int          ext, n;
    #1;
    {n_rr, n_rw, n_yr, n_pm, n_dr} = '0;
    check("ready idle", 24'(ready), 24'h1);
    xa = adj(x_ea, x_am, x_ms, x_me, x_we);
    ya = adj(y_ea, y_am, y_ms, y_me, 1'b0);
    acc = kind == KIND_MULT_ACC_PREFETCH || kind == KIND_MULT_ACC_PLAIN;
    win = xa[15] & win_en & ~tbusy;
    pr = win && !x_we;
    xok = !win && xa < 16'h0100 && (x_we || !acc || xa < 16'h0080 &&
          (x_ptr == PTR_X_PREFETCH_A || x_ptr == PTR_X_PREFETCH_B));
    yq = acc && y_req;
    yok = yq && (y_ptr == PTR_Y_PREFETCH_A || y_ptr == PTR_Y_PREFETCH_B) &&
          ya >= 16'h0080 && ya <= 16'h00ff;
    ext = (kind == KIND_OTHER || kind == KIND_MULT_ACC_PLAIN) ? 2 : 1;
    ext = rep[4] ? ((|rep[3:0]) ? 2 : 0) : ext;
    ext = pr ? ext : 0;
    xe = pr ? pmw({1'b0, page, xa[14:0]}) : (xok ? mem(xa) : 16'h0000);
    ye = yok ? mem(ya) : 16'h0000;
    @(posedge clk_in);
    x_req <= 1'b0;
    y_req <= 1'b0;
    n = 0;
    do
    begin
      @(posedge clk_in);
      #1;
      n++;
    end
    while (done !== 1'b1 && n < 12);
    check("latency", 24'(n), 24'(2 + ext));
    if (!x_we) check("x data", x_rd, 24'(xe));
    if (yq) check("y data", y_rd, 24'(ye));
    check("pm reads", n_pm, 24'(pr));
    if (pr) check("pm addr", a_pm, {1'b0, page, xa[14:0]});
    check("ram reads", n_rr, 24'(xok && !x_we));
    if (xok && !x_we) check("ram raddr", a_rr, 24'(xa));
    check("ram writes", n_rw, 24'(xok && x_we));
    if (xok && x_we) check("ram waddr", a_rw, 24'(xa));
    if (xok && x_we) check("ram wdata", d_rw, 24'(x_wd));
    check("y reads", n_yr, 24'(yok));
    if (yok) check("y addr", a_yr, 24'(ya));
    check("window drops", n_dr, 24'(win && x_we));
  endtask

  // random fields, forced corners for the first sixteen accesses
  task automatic stim(input int it);
    logic [15:0] xs, ys, ea, yea;
    dsm_amode_t  am, yam;
    logic        we, en, tb;
    logic [4:0]  rp;
    logic [7:0]  pg;
    dsm_kind_t   k;
    xs = 16'h0002 + (16'({$random(seed)} % 108) & 16'hfffe);
    ys = xs | 16'h0080;
    am = dsm_amode_t'({$random(seed)} % 3);
    yam = dsm_amode_t'({$random(seed)} % 3);
    ea = rnd_ea($random(seed), $random(seed));
    if (am == AMODE_MODULO) ea = xs - 16'h0002 + 16'(2 * ({$random(seed)} % 11));
    yea = rnd_ea($random(seed), $random(seed));
    if (yam == AMODE_MODULO) yea = ys - 16'h0002 + 16'(2 * ({$random(seed)} % 11));
    we = {$random(seed)} % 4 == 0;
    en = 1'($random(seed));
    tb = {$random(seed)} % 8 == 0;
    rp = 5'($random(seed));
    pg = 8'($random(seed));
    k = dsm_kind_t'({$random(seed)} % 5);
    if (it < 16)
    begin
      ea = (it == 4 || it == 5) ? 16'h0002 : 16'hfffe - 16'(it * 16'h0202);
      am = (it == 4 || it == 5) ? AMODE_BITREV : AMODE_LINEAR;
      we = it == 3 || it == 4;
      en = it != 2;
      tb = it == 1;
      pg = 8'hff - 8'(it);
      k = (it >= 6 && it <= 10) ? dsm_kind_t'(it - 6) : KIND_OTHER;
      rp = (it >= 11) ? (5'h10 | (5'h10 >> (it - 10))) : 5'h00;
    end
    @(posedge clk_in);
    x_req <= 1'b1;
    x_we <= we;
    x_ea <= ea;
    x_am <= am;
    x_ms <= xs;
    x_me <= xs + 16'h0010;
    x_wd <= 16'($random(seed));
    x_ptr <= dsm_ptr_t'({$random(seed)} % 5);
    y_req <= 1'($random(seed));
    y_ea <= yea;
    y_am <= yam;
    y_ms <= ys;
    y_me <= ys + 16'h0010;
    y_ptr <= dsm_ptr_t'({$random(seed)} % 5);
    win_en <= en;
    tbusy <= tb;
    rep <= rp;
    page <= pg;
    kind <= k;
    go();
  endtask

  // reset, then four enabled edges before the first request
  initial
  begin
    // a real falling edge, so the asynchronous reset acts at once
    rstn_in <= 1'b0;
    #1;
    check("ready in reset", 24'(ready), 24'h1);
    check("done in reset", 24'(done), 24'h0);
    repeat (4) @(posedge clk_in);
    rstn_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    for (int it = 0; it < 300; it++)
      stim(it);
    wrap_up();
  end

  // four to six cycles per access; far more than that means a hang
  initial
  begin
    #(50 * 20000);
    miscompares++;
    wrap_up();
  end
endmodule

// ==== verilog/dsm_data_router.sv ====
// Purpose: data space decode, x/y routing and program window access
// Assumes: synchronous memories answer one cycle after their strobe
// Notes:   whole state sits in one packed struct register
// Function
// - upper data half maps onto program page
// - window needs msb set and enable bit
// - low 15 bits from ea, next 8 page, msb zero
// - window read returns low 16 bits only
// - window off while table access runs
// - moves and prefetch accumulate add one cycle
// - other instructions add two cycles
// - repeat loop edges add two cycles
// - other repeat iterations add nothing
// - upper half always x, never y
// - non accumulate instructions see linear space
// - accumulate reads split x/y by pointer
// - concurrent x/y only for accumulate class
// - all writes over x bus, none y
// - y path only for accumulate class, prefetch or plain
// - modulo both paths, bit reverse x writes
// - write-back may reach any implemented address
// - out of region reads return zero
// - x/y boundary fixed in hardware
`timescale 1ns/1ps
`include "dsm_map.svh"
module dsm_data_router
  import dsm_pkg::*;
#(
  parameter int RAM_BYTES = `DSM_RAM_BYTES,
  parameter int BR_BITS   = `DSM_BR_BITS
)(
  input  wire logic        clk_in,
  input  wire logic        rstn_in,
  input  wire logic        ce_in,
  input  wire logic        program_window_enable_in,
  input  wire logic [7:0]  program_window_page_in,
  input  wire logic        table_busy_in,
  input  wire dsm_kind_t   kind_in,
  input  wire logic        rep_active_in,
  input  wire logic        rep_first_in,
  input  wire logic        rep_last_in,
  input  wire logic        rep_irq_exit_in,
  input  wire logic        rep_irq_reentry_in,
  input  wire logic        x_req_in,
  input  wire logic        x_we_in,
  input  wire logic [15:0] x_ea_in,
  input  wire dsm_ptr_t    x_ptr_in,
  input  wire dsm_amode_t  x_amode_in,
  input  wire logic [15:0] x_mod_start_in,
  input  wire logic [15:0] x_mod_end_in,
  input  wire logic [15:0] x_wdata_in,
  input  wire logic        y_req_in,
  input  wire logic [15:0] y_ea_in,
  input  wire dsm_ptr_t    y_ptr_in,
  input  wire dsm_amode_t  y_amode_in,
  input  wire logic [15:0] y_mod_start_in,
  input  wire logic [15:0] y_mod_end_in,
  output logic             ready_out,
  output logic             done_out,
  output logic      [15:0] x_rdata_out,
  output logic      [15:0] y_rdata_out,
  output logic             win_write_drop_out,
  output logic             ram_re_out,
  output logic             ram_we_out,
  output logic      [15:0] ram_addr_out,
  output logic      [15:0] ram_wdata_out,
  input  wire logic [15:0] ram_rdata_in,
  output logic             yram_re_out,
  output logic      [15:0] yram_addr_out,
  input  wire logic [15:0] yram_rdata_in,
  output logic             pm_re_out,
  output logic      [23:0] pm_addr_out,
  input  wire logic [23:0] pm_rdata_in
);

  // refuse sizes the 16-bit decode cannot serve
  initial
  begin
    if (RAM_BYTES < 2 || RAM_BYTES > 32768)
      $error("data memory size out of range");
    if (BR_BITS < 1 || BR_BITS > 14)
      $error("bit reverse width out of range");
  end

  localparam logic [16:0] RAM_LIMIT = 17'(RAM_BYTES);

  logic        rst_s1_q;
  logic        rst_s2_q;
  logic        rst_n;
  dsm_regs_t   r_q;
  dsm_regs_t   r_d;
  logic [15:0] x_ea;
  logic [15:0] y_ea;
  logic        macc_class;
  logic        one_grp;
  logic        rep_edge;
  logic        x_win;
  logic        x_in_y;
  logic        x_impl;
  logic        x_ptr_ok;
  logic        x_rd_ok;
  logic        x_wr_ok;
  logic        y_go;
  logic        y_ok;
  logic        take;
  logic [1:0]  x_extra;

  // reset release through two flops, assertion stays asynchronous
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      rst_s1_q <= `DSM_RST_VAL;
      rst_s2_q <= `DSM_RST_VAL;
    end
    else if (ce_in)
    begin
      rst_s1_q <= 1'h1;
      rst_s2_q <= rst_s1_q;
    end
  end
  assign rst_n = rst_s2_q;

  // address modifiers; bit reversal only on x writes
  dsm_ea_adjust #(.BR_BITS(BR_BITS)) u_x_adj (
    .ea_in        (x_ea_in),
    .mode_in      (x_amode_in),
    .br_allow_in  (x_we_in),
    .mod_start_in (x_mod_start_in),
    .mod_end_in   (x_mod_end_in),
    .ea_out       (x_ea)
  );

  dsm_ea_adjust #(.BR_BITS(BR_BITS)) u_y_adj (
    .ea_in        (y_ea_in),
    .mode_in      (y_amode_in),
    .br_allow_in  (1'h0),
    .mod_start_in (y_mod_start_in),
    .mod_end_in   (y_mod_end_in),
    .ea_out       (y_ea)
  );

  // instruction classification
  assign macc_class = (kind_in == KIND_MULT_ACC_PREFETCH) || (kind_in == KIND_MULT_ACC_PLAIN);
  assign one_grp    = (kind_in == KIND_MOVE_INSTRUCTION)
                   || (kind_in == KIND_DOUBLE_MOVE_INSTRUCTION)
                   || (kind_in == KIND_MULT_ACC_PREFETCH);
  assign rep_edge   = rep_first_in || rep_last_in || rep_irq_exit_in || rep_irq_reentry_in;

  // window steal: msb set, enabled, no table access in flight
  assign x_win = x_ea[`DSM_WIN_BIT] && program_window_enable_in && !table_busy_in;

  // y block bounds are constants, never software state
  assign x_in_y = (x_ea >= `DSM_Y_BASE) && (x_ea <= `DSM_Y_LAST);
  assign x_impl = {1'h0, x_ea} < RAM_LIMIT;

  // accumulate reads on x need an x prefetch pointer
  assign x_ptr_ok = !macc_class || x_we_in
                 || (x_ptr_in == PTR_X_PREFETCH_A) || (x_ptr_in == PTR_X_PREFETCH_B);

  // non accumulate reads see y addresses as plain linear space
  assign x_rd_ok = x_win
                || (x_impl && x_ptr_ok && !(macc_class && x_in_y));

  // writes: combined space over x, never through the window
  assign x_wr_ok = !x_win && x_impl;

  // y path only for accumulate class, only the y block, only y pointers
  assign y_go = y_req_in && macc_class;
  assign y_ok = (y_ea >= `DSM_Y_BASE) && (y_ea <= `DSM_Y_LAST)
             && ((y_ptr_in == PTR_Y_PREFETCH_A) || (y_ptr_in == PTR_Y_PREFETCH_B));

  // window cost: one or two extra cycles by instruction class, free in steady repeat
  always_comb
  begin
    x_extra = `DSM_EXTRA_NONE;
    if (x_win && !x_we_in)
    begin
      if (rep_active_in)
        x_extra = rep_edge ? `DSM_EXTRA_TWO : `DSM_EXTRA_NONE;
      else
        x_extra = one_grp ? `DSM_EXTRA_ONE : `DSM_EXTRA_TWO;
    end
  end

  assign ready_out = (r_q.st == DSM_IDLE);
  assign take      = ready_out && (x_req_in || y_go);

  // sequencer: take, strobe memories, capture, pay extra cycles
  always_comb
  begin
    r_d          = r_q;
    r_d.done     = 1'h0;
    r_d.win_drop = 1'h0;
    case (r_q.st)
      DSM_IDLE:
      begin
        if (take)
        begin
          r_d.st        = DSM_ACCESS;
          r_d.cnt       = x_extra;
          r_d.x_read    = x_req_in && !x_we_in;
          r_d.x_win     = x_req_in && x_win;
          r_d.x_zero    = !(x_req_in && !x_we_in && x_rd_ok);
          r_d.ram_re    = x_req_in && !x_we_in && x_rd_ok && !x_win;
          r_d.ram_we    = x_req_in && x_we_in && x_wr_ok;
          r_d.ram_addr  = x_ea;
          r_d.ram_wdata = x_wdata_in;
          r_d.pm_re     = x_req_in && !x_we_in && x_win;
          r_d.pm_addr   = {1'h0, program_window_page_in,
                           x_ea[`DSM_PM_LOW_BITS-1:0]};
          r_d.win_drop  = x_req_in && x_we_in && x_win;
          r_d.yram_re   = y_go && y_ok;
          r_d.yram_addr = y_ea;
          r_d.y_zero    = !(y_go && y_ok);
        end
      end
      DSM_ACCESS:
      begin
        // strobes last exactly one cycle
        r_d.ram_re  = 1'h0;
        r_d.ram_we  = 1'h0;
        r_d.pm_re   = 1'h0;
        r_d.yram_re = 1'h0;
        r_d.st      = DSM_CAPTURE;
      end
      DSM_CAPTURE:
      begin
        if (r_q.x_zero)
          r_d.x_rdata = `DSM_ZERO_WORD;
        else if (r_q.x_win)
          r_d.x_rdata = pm_rdata_in[15:0];
        else
          r_d.x_rdata = ram_rdata_in;
        r_d.y_rdata = r_q.y_zero ? `DSM_ZERO_WORD : yram_rdata_in;
        if (r_q.cnt == `DSM_EXTRA_NONE)
        begin
          r_d.done = 1'h1;
          r_d.st   = DSM_IDLE;
        end
        else
        begin
          r_d.st = DSM_WAIT;
        end
      end
      DSM_WAIT:
      begin
        // data already held; only the charged cycles remain
        r_d.cnt = r_q.cnt - 2'h1;
        if (r_q.cnt == `DSM_EXTRA_ONE)
        begin
          r_d.done = 1'h1;
          r_d.st   = DSM_IDLE;
        end
      end
      default:
      begin
        r_d.st = DSM_IDLE;
      end
    endcase
  end

  // whole state in one register, frozen while ce is low
  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
      r_q <= '0;
    else if (ce_in)
      r_q <= r_d;
  end

  assign done_out           = r_q.done;
  assign x_rdata_out        = r_q.x_rdata;
  assign y_rdata_out        = r_q.y_rdata;
  assign win_write_drop_out = r_q.win_drop;
  assign ram_re_out         = r_q.ram_re;
  assign ram_we_out         = r_q.ram_we;
  assign ram_addr_out       = r_q.ram_addr;
  assign ram_wdata_out      = r_q.ram_wdata;
  assign yram_re_out        = r_q.yram_re;
  assign yram_addr_out      = r_q.yram_addr;
  assign pm_re_out          = r_q.pm_re;
  assign pm_addr_out        = r_q.pm_addr;

  // checks count only enabled cycles, like the state does
  default clocking cb @(posedge clk_in iff ce_in);
  endclocking
  default disable iff (!rst_n);

  sequence s_win_take;
    take && x_req_in && !x_we_in && x_win;
  endsequence

  sequence s_win_read;
    s_win_take ##1 pm_re_out ##1 1'h1;
  endsequence

  a_window_addr: assert property (
    s_win_take |=> pm_re_out && !ram_re_out
      && (pm_addr_out[14:0] == $past(x_ea[14:0]))
      && (pm_addr_out[22:15] == $past(program_window_page_in)) && !pm_addr_out[23])
    else $error("window address not built from page and ea");

  a_table_block: assert property (
    (take && table_busy_in) |=> !pm_re_out)
    else $error("window used during table access");

  a_window_data: assert property (
    s_win_read |=> (x_rdata_out == $past(pm_rdata_in[15:0])))
    else $error("window read data not low program word");

  a_one_extra: assert property (
    (s_win_take and (!rep_active_in && one_grp)) |=> !done_out [*3] ##1 done_out)
    else $error("one extra cycle not charged");

  a_two_extra: assert property (
    (s_win_take and (!rep_active_in && !one_grp)) |=> !done_out [*4] ##1 done_out)
    else $error("two extra cycles not charged");

  a_rep_edge: assert property (
    (s_win_take and (rep_active_in && rep_edge)) |=> !done_out [*4] ##1 done_out)
    else $error("repeat edge iteration not charged two");

  a_rep_fast: assert property (
    (s_win_take and (rep_active_in && !rep_edge)) |-> ##3 done_out)
    else $error("steady repeat iteration was slowed");

  a_macc_y_zero: assert property (
    (take && x_req_in && !x_we_in && macc_class && x_in_y && !x_win)
      |-> ##1 !ram_re_out ##2 (x_rdata_out == `DSM_ZERO_WORD))
    else $error("accumulate x read of y block not zero");

  a_y_gated: assert property (
    (take && y_req_in && !macc_class) |=> !yram_re_out)
    else $error("y path used outside accumulate class");

  a_y_outside: assert property (
    (take && y_go && !y_ok) |-> ##3 (y_rdata_out == `DSM_ZERO_WORD))
    else $error("y read outside y block not zero");

  a_write_any: assert property (
    (take && x_req_in && x_we_in && x_wr_ok)
      |=> ram_we_out && (ram_addr_out == $past(x_ea))
        && (ram_wdata_out == $past(x_wdata_in)))
    else $error("write not issued on x bus");

  a_unimpl_zero: assert property (
    (take && x_req_in && !x_we_in && !program_window_enable_in && x_ea[15])
      |-> ##1 !pm_re_out ##2 (x_rdata_out == `DSM_ZERO_WORD))
    else $error("disabled window upper read not zero");

endmodule

// ==== verilog/dsm_ea_adjust.sv ====
// Purpose: modulo and bit-reversed correction of one effective address
// Assumes: pointers step by whole words, so modulo wraps by two bytes
// Notes:   purely combinational; bit reversal only where the caller allows
`timescale 1ns/1ps
`include "dsm_map.svh"
module dsm_ea_adjust
  import dsm_pkg::*;
#(
  parameter int BR_BITS = `DSM_BR_BITS
)(
  input  wire logic [15:0] ea_in,
  input  wire dsm_amode_t  mode_in,
  input  wire logic        br_allow_in,
  input  wire logic [15:0] mod_start_in,
  input  wire logic [15:0] mod_end_in,
  output logic      [15:0] ea_out
);

  // reversal works on word offsets, bit 0 stays the byte select
  initial
  begin
    if (BR_BITS < 1 || BR_BITS > 14)
      $error("bit reverse width out of range");
  end

  logic [15:0] rev;

  // mirror bits BR_BITS..1, keep the rest as they are
  assign rev[0] = ea_in[0];
  genvar gi;
  generate
    for (gi = 1; gi < 16; gi++)
    begin : g_rev
      if (gi <= BR_BITS)
      begin : g_swap
        assign rev[gi] = ea_in[BR_BITS + 1 - gi];
      end
      else
      begin : g_keep
        assign rev[gi] = ea_in[gi];
      end
    end
  endgenerate

  // modulo wraps to the other end of the buffer
  always_comb
  begin
    ea_out = ea_in;
    case (mode_in)
      AMODE_MODULO:
      begin
        if (ea_in > mod_end_in)
          ea_out = mod_start_in + (ea_in - mod_end_in - `DSM_MOD_STEP);
        else if (ea_in < mod_start_in)
          ea_out = mod_end_in + `DSM_MOD_STEP - (mod_start_in - ea_in);
      end
      AMODE_BITREV:
      begin
        if (br_allow_in)
          ea_out = rev;
      end
      default:
      begin
        ea_out = ea_in;
      end
    endcase
  end

endmodule

// ==== verilog/dsm_map.svh ====
// Purpose: fixed constants of the data space router
// Assumes: included by bare name wherever a constant is needed
// Notes:   the x/y boundary is hardwired; software cannot move it
`ifndef DSM_MAP_SVH
`define DSM_MAP_SVH

// physical data space and the fixed y block inside it
`define DSM_RAM_BYTES   256
`define DSM_Y_BASE      16'h0080
`define DSM_Y_LAST      16'h00ff

// program window address construction
`define DSM_WIN_BIT     15
`define DSM_PM_LOW_BITS 15

// extra cycles charged for a program window access
`define DSM_EXTRA_NONE  2'h0
`define DSM_EXTRA_ONE   2'h1
`define DSM_EXTRA_TWO   2'h2

// misc values
`define DSM_ZERO_WORD   16'h0000
`define DSM_MOD_STEP    16'h0002
`define DSM_BR_BITS     7
`define DSM_RST_VAL     1'h0

`endif

// ==== verilog/dsm_pkg.sv ====
// Purpose: types shared by the data space router files
// Assumes: nothing beyond plain synthesizable types
// Notes:   enums carry no explicit codes
package dsm_pkg;

  // access sequencer states
  typedef enum logic [1:0] {DSM_IDLE, DSM_ACCESS, DSM_CAPTURE, DSM_WAIT} dsm_fsm_t;

  // instruction kind reported by the execution core
  typedef enum logic [2:0] {
    KIND_MOVE_INSTRUCTION,
    KIND_DOUBLE_MOVE_INSTRUCTION,
    KIND_MULT_ACC_PREFETCH,
    KIND_MULT_ACC_PLAIN,
    KIND_OTHER
  } dsm_kind_t;

  // pointer that produced an effective address
  typedef enum logic [2:0] {
    PTR_OTHER,
    PTR_X_PREFETCH_A,
    PTR_X_PREFETCH_B,
    PTR_Y_PREFETCH_A,
    PTR_Y_PREFETCH_B
  } dsm_ptr_t;

  // address modifier mode
  typedef enum logic [1:0] {AMODE_LINEAR, AMODE_MODULO, AMODE_BITREV} dsm_amode_t;

  // complete state of the router
  typedef struct packed {
    dsm_fsm_t    st;
    logic [1:0]  cnt;
    logic        x_win;
    logic        x_zero;
    logic        x_read;
    logic        y_zero;
    logic        ram_re;
    logic        ram_we;
    logic [15:0] ram_addr;
    logic [15:0] ram_wdata;
    logic        yram_re;
    logic [15:0] yram_addr;
    logic        pm_re;
    logic [23:0] pm_addr;
    logic [15:0] x_rdata;
    logic [15:0] y_rdata;
    logic        done;
    logic        win_drop;
  } dsm_regs_t;

endpackage
